// ---- logic/flash_ctl_pkg.sv ----
// package: register map, field positions, reset values and timing of the flash program/erase control
// Summary of operation
// - latch-only with erase clear: trigger loads row latch word, no flash operation
// - latch-only clear: next trigger writes latched data, or erases if erase selected on a flash address
// - latch-only ignored when erase select is set on a flash (program-space) address
// - erase select on flash address: trigger erases whole 32-word pseudo-row to ones
// - erase select reads zero after erase finishes normally; hardware clears it
// - error flag set on reset-cut write, broken unlock, or protected address
// - program/erase enable low blocks every program and erase of flash
// - trigger accepted only after the unlock sequence, with no control or unlock write in between
// - writing zero to trigger during an operation is ignored
package flash_ctl_pkg;
    localparam logic [7:0] ctl_offset = 8'h00;
    localparam logic [7:0] unlock_offset = 8'h04;
    localparam logic [7:0] addr_offset = 8'h08;
    localparam logic [7:0] irq_status_offset = 8'h0c;
    localparam logic [7:0] irq_mask_offset = 8'h10;
    localparam logic [7:0] protect_offset = 8'h14;
    localparam int config_space_bit = 6;
    localparam int latch_only_bit = 5;
    localparam int erase_select_bit = 4;
    localparam int error_bit = 3;
    localparam int enable_bit = 2;
    localparam int trigger_bit = 1;
    localparam logic [7:0] ctl_reset = 8'h00;
    localparam logic [7:0] unlock_first = 8'h55;
    localparam logic [7:0] unlock_second = 8'haa;
    localparam logic [14:0] protect_reset = 15'h0000;
    localparam int row_words = 32;
    localparam int clk_mhz = 200;
    localparam int write_time_us = 2;
    localparam int erase_time_us = 2;
    localparam int write_cycles = write_time_us * clk_mhz;
    localparam int erase_cycles = erase_time_us * clk_mhz;
    // irq status bits: 0 done, 1 error, 2 latch loaded
    localparam int irq_done_bit = 0;
    localparam int irq_error_bit = 1;
    localparam int irq_latch_bit = 2;
    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_write = 2'b01,
        st_erase = 2'b11
    } op_state_e;
endpackage

// ---- logic/flash_op_timer.sv ----
// module: countdown timer for one flash write or erase
`timescale 1ns/100ps
module flash_op_timer #(
    parameter int count_w = 12
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic start,
    input wire logic [count_w-1:0] cycles,
    output logic busy,
    output logic done
);
    typedef struct packed {
        logic [count_w-1:0] cnt;
        logic busy;
        logic done;
    } tmr_s;
    tmr_s st_ff;
    tmr_s nxt_st;

    if (count_w < 2) begin : g_bad_count_w
        $error("count_w too small");
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_st.done = 1'b0;
        if (start && !st_ff.busy) begin
            nxt_st.busy = 1'b1;
            nxt_st.cnt = cycles;
        end else if (st_ff.busy) begin
            if (st_ff.cnt <= count_w'(1)) begin
                nxt_st.busy = 1'b0;
                nxt_st.done = 1'b1;
            end else begin
                nxt_st.cnt = st_ff.cnt - count_w'(1);
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign busy = st_ff.busy;
    assign done = st_ff.done;
endmodule // flash_op_timer

// ---- logic/flash_program_erase_control.sv ----
// module: flash program/erase control with axi4-lite registers and sequencer requests
`timescale 1ns/100ps
module flash_program_erase_control #(
    parameter int addr_w = 15,
    parameter int timer_w = 12
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic latch_load,
    output logic flash_write,
    output logic row_erase,
    output logic [addr_w-1:0] op_address,
    output logic irq
);
    typedef struct packed {
        logic aw_got;
        logic [7:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] ctl;
        logic [1:0] unlock_stage;
        logic [addr_w-1:0] addr;
        logic [addr_w-1:0] protect_limit;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        flash_ctl_pkg::op_state_e op;
        logic latch_load;
        logic flash_write;
        logic row_erase;
        logic irq;
        logic first_cycle;
        logic awready;
        logic wready;
        logic arready;
    } ctl_s;
    ctl_s st_ff;
    ctl_s nxt_st;
    logic tmr_start;
    logic [timer_w-1:0] tmr_cycles;
    logic tmr_busy;
    logic tmr_done;

    if (addr_w < 6 || addr_w > 32) begin : g_bad_addr_w
        $error("addr_w out of range");
    end
    if (timer_w < $clog2(flash_ctl_pkg::write_cycles + 1) || timer_w < $clog2(flash_ctl_pkg::erase_cycles + 1))
    begin : g_bad_timer_w
        $error("timer_w cannot hold operation time");
    end

    function automatic logic is_protected(input logic [addr_w-1:0] a, input logic [addr_w-1:0] lim);
        is_protected = a < lim;
    endfunction

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = a == flash_ctl_pkg::ctl_offset || a == flash_ctl_pkg::unlock_offset
            || a == flash_ctl_pkg::addr_offset || a == flash_ctl_pkg::irq_status_offset
            || a == flash_ctl_pkg::irq_mask_offset || a == flash_ctl_pkg::protect_offset;
    endfunction

    flash_op_timer #(.count_w(timer_w)) op_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(tmr_start),
        .cycles(tmr_cycles),
        .busy(tmr_busy),
        .done(tmr_done)
    );

    // =====================================================
    // register access and operation control
    always_comb begin
        logic do_write;
        logic do_read;
        logic [7:0] wb;
        logic trig;
        logic pgm_space;
        logic [2:0] ev;
        do_write = 1'b0;
        do_read = 1'b0;
        wb = 8'h00;
        trig = 1'b0;
        pgm_space = 1'b0;
        ev = 3'b000;
        nxt_st = st_ff;
        nxt_st.first_cycle = 1'b0;
        nxt_st.latch_load = 1'b0;
        nxt_st.flash_write = 1'b0;
        nxt_st.row_erase = 1'b0;
        tmr_start = 1'b0;
        tmr_cycles = timer_w'(flash_ctl_pkg::write_cycles);
        // a write cut by reset is only visible after reset: flag it on the first cycle
        if (st_ff.first_cycle) begin
            if (st_ff.op != flash_ctl_pkg::st_idle) begin
                nxt_st.ctl[flash_ctl_pkg::error_bit] = 1'b1;
            end
            // the timer was reset too, so nothing else would ever end the cut operation
            nxt_st.op = flash_ctl_pkg::st_idle;
        end
        if (s_axi_awvalid && !st_ff.aw_got) begin
            nxt_st.aw_got = 1'b1;
            nxt_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_ff.w_got) begin
            nxt_st.w_got = 1'b1;
            nxt_st.w_data = s_axi_wdata;
            nxt_st.w_strb = s_axi_wstrb;
        end
        if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid) begin
            do_write = 1'b1;
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = is_mapped(st_ff.aw_addr) ? 2'b00 : 2'b10;
        end
        if (st_ff.bvalid && s_axi_bready) nxt_st.bvalid = 1'b0;
        if (st_ff.rvalid && s_axi_rready) nxt_st.rvalid = 1'b0;
        wb = st_ff.w_strb[0] ? st_ff.w_data[7:0] : 8'h00;
        // =====================================================
        // register writes
        if (do_write && st_ff.w_strb[0]) begin
            unique case (st_ff.aw_addr)
                flash_ctl_pkg::ctl_offset: begin
                    // trigger is set-only and busy fields hold while an operation runs
                    if (st_ff.op == flash_ctl_pkg::st_idle) begin
                        nxt_st.ctl[6:2] = wb[6:2];
                        trig = wb[flash_ctl_pkg::trigger_bit];
                    end
                    // any control write breaks a pending unlock
                    nxt_st.unlock_stage = 2'd0;
                end
                flash_ctl_pkg::unlock_offset: begin
                    if (st_ff.unlock_stage == 2'd0 && wb == flash_ctl_pkg::unlock_first) begin
                        nxt_st.unlock_stage = 2'd1;
                    end else if (st_ff.unlock_stage == 2'd1 && wb == flash_ctl_pkg::unlock_second) begin
                        nxt_st.unlock_stage = 2'd2;
                    end else begin
                        nxt_st.unlock_stage = 2'd0;
                        if (st_ff.unlock_stage != 2'd0) begin
                            nxt_st.ctl[flash_ctl_pkg::error_bit] = 1'b1;
                            ev[flash_ctl_pkg::irq_error_bit] = 1'b1;
                        end
                    end
                end
                flash_ctl_pkg::addr_offset: begin
                    if (st_ff.op == flash_ctl_pkg::st_idle) nxt_st.addr = st_ff.w_data[addr_w-1:0];
                end
                flash_ctl_pkg::irq_mask_offset: nxt_st.irq_mask = st_ff.w_data[2:0];
                flash_ctl_pkg::protect_offset: nxt_st.protect_limit = st_ff.w_data[addr_w-1:0];
                default: ;
            endcase
        end
        // =====================================================
        // trigger handling
        pgm_space = !st_ff.ctl[flash_ctl_pkg::config_space_bit];
        if (trig) begin
            if (st_ff.unlock_stage != 2'd2) begin
                // trigger without unlock starts nothing
                nxt_st.ctl[flash_ctl_pkg::error_bit] = 1'b1;
                ev[flash_ctl_pkg::irq_error_bit] = 1'b1;
            end else if (!wb[flash_ctl_pkg::enable_bit]) begin
                tmr_start = 1'b0;
            end else if (pgm_space && is_protected(st_ff.addr, st_ff.protect_limit)) begin
                nxt_st.ctl[flash_ctl_pkg::error_bit] = 1'b1;
                ev[flash_ctl_pkg::irq_error_bit] = 1'b1;
            end else if (wb[flash_ctl_pkg::erase_select_bit] && pgm_space) begin
                nxt_st.op = flash_ctl_pkg::st_erase;
                nxt_st.ctl[flash_ctl_pkg::trigger_bit] = 1'b1;
                nxt_st.ctl[flash_ctl_pkg::error_bit] = 1'b0;
                nxt_st.row_erase = 1'b1;
                tmr_start = 1'b1;
                tmr_cycles = timer_w'(flash_ctl_pkg::erase_cycles);
            end else if (wb[flash_ctl_pkg::latch_only_bit]) begin
                nxt_st.latch_load = 1'b1;
                nxt_st.ctl[flash_ctl_pkg::error_bit] = 1'b0;
                ev[flash_ctl_pkg::irq_latch_bit] = 1'b1;
            end else begin
                nxt_st.op = flash_ctl_pkg::st_write;
                nxt_st.ctl[flash_ctl_pkg::trigger_bit] = 1'b1;
                nxt_st.ctl[flash_ctl_pkg::error_bit] = 1'b0;
                nxt_st.flash_write = 1'b1;
                tmr_start = 1'b1;
            end
            nxt_st.unlock_stage = 2'd0;
        end
        if (tmr_done && st_ff.op != flash_ctl_pkg::st_idle) begin
            nxt_st.op = flash_ctl_pkg::st_idle;
            nxt_st.ctl[flash_ctl_pkg::trigger_bit] = 1'b0;
            nxt_st.ctl[flash_ctl_pkg::erase_select_bit] = 1'b0;
            ev[flash_ctl_pkg::irq_done_bit] = 1'b1;
        end
        // =====================================================
        // reads; read of status clears it, but events of this cycle survive
        if (s_axi_arvalid && !st_ff.rvalid) begin
            do_read = 1'b1;
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp = is_mapped(s_axi_araddr) ? 2'b00 : 2'b10;
            nxt_st.rdata = 32'h0000_0000;
            unique case (s_axi_araddr)
                flash_ctl_pkg::ctl_offset: nxt_st.rdata[7:0] = {1'b0, st_ff.ctl[6:2], st_ff.ctl[1], 1'b0};
                flash_ctl_pkg::unlock_offset: nxt_st.rdata = 32'h0000_0000;
                flash_ctl_pkg::addr_offset: nxt_st.rdata[addr_w-1:0] = st_ff.addr;
                flash_ctl_pkg::irq_status_offset: nxt_st.rdata[2:0] = st_ff.irq_stat;
                flash_ctl_pkg::irq_mask_offset: nxt_st.rdata[2:0] = st_ff.irq_mask;
                flash_ctl_pkg::protect_offset: nxt_st.rdata[addr_w-1:0] = st_ff.protect_limit;
                default: ;
            endcase
        end
        if (do_read && s_axi_araddr == flash_ctl_pkg::irq_status_offset) begin
            nxt_st.irq_stat = ev;
        end else begin
            nxt_st.irq_stat = st_ff.irq_stat | ev;
        end
        nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_mask);
        nxt_st.awready = !nxt_st.aw_got;
        nxt_st.wready = !nxt_st.w_got;
        nxt_st.arready = !nxt_st.rvalid;
    end

    // =====================================================
    // state register; op state is held through reset so a cut write is noticed
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= '0;
            st_ff.ctl <= flash_ctl_pkg::ctl_reset;
            st_ff.protect_limit <= addr_w'(flash_ctl_pkg::protect_reset);
            st_ff.op <= st_ff.op;
            st_ff.first_cycle <= 1'b1;
            st_ff.awready <= 1'b1;
            st_ff.wready <= 1'b1;
            st_ff.arready <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign s_axi_awready = st_ff.awready;
    assign s_axi_wready = st_ff.wready;
    assign s_axi_bvalid = st_ff.bvalid;
    assign s_axi_bresp = st_ff.bresp;
    assign s_axi_arready = st_ff.arready;
    assign s_axi_rvalid = st_ff.rvalid;
    assign s_axi_rdata = st_ff.rdata;
    assign s_axi_rresp = st_ff.rresp;
    assign latch_load = st_ff.latch_load;
    assign flash_write = st_ff.flash_write;
    assign row_erase = st_ff.row_erase;
    assign op_address = st_ff.addr;
    assign irq = st_ff.irq;

    // =====================================================
    // assertions
    a_trig_clear_on_done: assert property (@(posedge aclk) disable iff (!aresetn)
        tmr_done && st_ff.op != flash_ctl_pkg::st_idle |=> !st_ff.ctl[flash_ctl_pkg::trigger_bit])
        else $error("trigger not cleared at completion");
    a_erase_sel_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        st_ff.op == flash_ctl_pkg::st_erase && tmr_done |=> !st_ff.ctl[flash_ctl_pkg::erase_select_bit])
        else $error("erase select not cleared");
    a_latch_no_op: assert property (@(posedge aclk) disable iff (!aresetn)
        latch_load |-> !flash_write && !row_erase && st_ff.op == flash_ctl_pkg::st_idle)
        else $error("latch load started an operation");
    a_write_runs: assert property (@(posedge aclk) disable iff (!aresetn)
        flash_write |-> st_ff.op == flash_ctl_pkg::st_write && st_ff.ctl[flash_ctl_pkg::trigger_bit])
        else $error("write pulse without write state");
    a_erase_sel: assert property (@(posedge aclk) disable iff (!aresetn)
        row_erase |-> st_ff.ctl[flash_ctl_pkg::erase_select_bit] && st_ff.op == flash_ctl_pkg::st_erase)
        else $error("erase without erase select");
    a_enable_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        flash_write || row_erase |-> st_ff.ctl[flash_ctl_pkg::enable_bit])
        else $error("operation while disabled");
    a_unlock_needed: assert property (@(posedge aclk) disable iff (!aresetn)
        tmr_start |-> st_ff.unlock_stage == 2'd2)
        else $error("operation without unlock");
    a_trig_holds: assert property (@(posedge aclk) disable iff (!aresetn)
        !st_ff.first_cycle && st_ff.op != flash_ctl_pkg::st_idle && !tmr_done
        |=> st_ff.ctl[flash_ctl_pkg::trigger_bit])
        else $error("trigger dropped during operation");
    a_error_protect: assert property (@(posedge aclk) disable iff (!aresetn)
        row_erase || flash_write |-> !st_ff.ctl[flash_ctl_pkg::error_bit])
        else $error("error flag set on good start");
    a_latch_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
        row_erase |-> ##0 !latch_load)
        else $error("latch acted during erase");
    c_erase: cover property (@(posedge aclk) disable iff (!aresetn) row_erase ##[1:1000] tmr_done);
    c_write: cover property (@(posedge aclk) disable iff (!aresetn) flash_write);
    c_latch: cover property (@(posedge aclk) disable iff (!aresetn) latch_load);
    c_irq: cover property (@(posedge aclk) disable iff (!aresetn) irq);
    c_cut_write: cover property (@(posedge aclk) st_ff.first_cycle && st_ff.op != flash_ctl_pkg::st_idle);
endmodule // flash_program_erase_control

// ---- testbench/flash_program_erase_control_bench.sv ----
// testbench: register-level checks of the flash program/erase control over axi4-lite
`timescale 1ns/100ps
module flash_program_erase_control_bench;
    // ==========================================================
    // signals
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [7:0] s_axi_araddr = 8'h00;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    logic latch_load;
    logic flash_write;
    logic row_erase;
    logic [14:0] op_address;
    logic irq;
    int n_mismatch = 0;
    int n_tests = 0;
    int n_latch = 0;
    int n_write = 0;
    int n_erase = 0;
    logic [1:0] resp;
    logic [31:0] d;

    flash_program_erase_control i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .latch_load, .flash_write, .row_erase, .op_address, .irq);

    initial begin
        forever #2.5 aclk = ~aclk;
    end

    // sequencer requests are single-cycle pulses, so they are counted rather than looked for
    always @(posedge aclk) begin
        if (latch_load === 1'b1) n_latch++;
        if (flash_write === 1'b1) n_write++;
        if (row_erase === 1'b1) n_erase++;
    end

    // ==========================================================
    // tasks
    task automatic report_and_stop();
        $display("mismatches %0d, comparisons %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= v;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
        end
        if (n == 100) begin
            n_mismatch++;
            report_and_stop();
        end
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) begin
                v = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
        end
        if (n == 100) begin
            n_mismatch++;
            report_and_stop();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [1:0] r;
        axi_write(a, v, r);
        check(r, 2'b00);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] v;
        logic [1:0] r;
        axi_read(a, v, r);
        check(r, 2'b00);
        check(v & m, e);
    endtask

    task automatic unlock();
        wr(flash_ctl_pkg::unlock_offset, 32'(flash_ctl_pkg::unlock_first));
        wr(flash_ctl_pkg::unlock_offset, 32'(flash_ctl_pkg::unlock_second));
    endtask

    // polls the trigger bit; the bound covers the 400-cycle operation with margin
    task automatic wait_idle();
        logic [31:0] v;
        logic [1:0] r;
        int n;
        for (n = 0; n < 1000; n++) begin
            axi_read(flash_ctl_pkg::ctl_offset, v, r);
            if (v[1] === 1'b0) break;
        end
        if (n == 1000) begin
            n_mismatch++;
            report_and_stop();
        end
    endtask

    task automatic cycles(input int k);
        repeat (k) @(posedge aclk);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        cycles(4);
        aresetn <= 1'b1;
        rd_chk(flash_ctl_pkg::ctl_offset, 32'hffff_ffff, 32'(flash_ctl_pkg::ctl_reset));
        rd_chk(flash_ctl_pkg::protect_offset, 32'hffff_ffff, 32'h0000_0000);
        rd_chk(flash_ctl_pkg::irq_mask_offset, 32'hffff_ffff, 32'h0000_0000);
        axi_read(8'h40, d, resp);
        check({30'h0, resp}, 32'h2);
        check(d, 32'h0);
        axi_write(8'h40, 32'h5a, resp);
        check({30'h0, resp}, 32'h2);
        // real write; a zero written to the trigger mid-operation must not stop it
        wr(flash_ctl_pkg::addr_offset, 32'h0123);
        wr(flash_ctl_pkg::irq_mask_offset, 32'h01);
        unlock();
        wr(flash_ctl_pkg::ctl_offset, 32'h06);
        cycles(4);
        check(n_write, 1);
        check({17'h0, op_address}, 32'h0123);
        wr(flash_ctl_pkg::ctl_offset, 32'h00);
        rd_chk(flash_ctl_pkg::ctl_offset, 32'h0e, 32'h06);
        wait_idle();
        rd_chk(flash_ctl_pkg::ctl_offset, 32'h0a, 32'h00);
        check({31'h0, irq}, 32'h1);
        rd_chk(flash_ctl_pkg::irq_status_offset, 32'hffff_ffff, 32'h01);
        cycles(3);
        check({31'h0, irq}, 32'h0);
        // pseudo-row erase
        unlock();
        wr(flash_ctl_pkg::ctl_offset, 32'h16);
        cycles(4);
        check(n_erase, 1);
        check(n_write, 1);
        wait_idle();
        rd_chk(flash_ctl_pkg::ctl_offset, 32'h1a, 32'h00);
        // latch-only load, then latch-only together with erase
        unlock();
        wr(flash_ctl_pkg::ctl_offset, 32'h26);
        cycles(4);
        check(n_latch, 1);
        check(n_write + n_erase, 2);
        rd_chk(flash_ctl_pkg::ctl_offset, 32'h02, 32'h00);
        unlock();
        wr(flash_ctl_pkg::ctl_offset, 32'h36);
        cycles(4);
        check(n_erase, 2);
        check(n_latch, 1);
        wait_idle();
        rd_chk(flash_ctl_pkg::irq_status_offset, 32'h04, 32'h04);
        // trigger with no unlock: refused, error raised, masked away from irq
        wr(flash_ctl_pkg::ctl_offset, 32'h06);
        cycles(4);
        check(n_write, 1);
        rd_chk(flash_ctl_pkg::ctl_offset, 32'h0a, 32'h08);
        check({31'h0, irq}, 32'h0);
        rd_chk(flash_ctl_pkg::irq_status_offset, 32'h02, 32'h02);
        // software clears the error, then a broken unlock sequence
        wr(flash_ctl_pkg::ctl_offset, 32'h00);
        rd_chk(flash_ctl_pkg::ctl_offset, 32'h08, 32'h00);
        wr(flash_ctl_pkg::unlock_offset, 32'h55);
        wr(flash_ctl_pkg::unlock_offset, 32'h11);
        rd_chk(flash_ctl_pkg::ctl_offset, 32'h08, 32'h08);
        wr(flash_ctl_pkg::ctl_offset, 32'h06);
        cycles(4);
        check(n_write, 1);
        rd_chk(flash_ctl_pkg::ctl_offset, 32'h0a, 32'h08);
        // unlocked trigger with the enable bit clear
        unlock();
        wr(flash_ctl_pkg::ctl_offset, 32'h02);
        cycles(4);
        check(n_write + n_erase + n_latch, 4);
        // protected address raises the error and the unmasked interrupt
        axi_read(flash_ctl_pkg::irq_status_offset, d, resp);
        wr(flash_ctl_pkg::irq_mask_offset, 32'h02);
        wr(flash_ctl_pkg::protect_offset, 32'h0200);
        cycles(3);
        check({31'h0, irq}, 32'h0);
        unlock();
        wr(flash_ctl_pkg::ctl_offset, 32'h06);
        cycles(4);
        check(n_write, 1);
        rd_chk(flash_ctl_pkg::ctl_offset, 32'h0a, 32'h08);
        check({31'h0, irq}, 32'h1);
        // reset in mid-write leaves the error flag set
        wr(flash_ctl_pkg::protect_offset, 32'h0000);
        unlock();
        wr(flash_ctl_pkg::ctl_offset, 32'h06);
        cycles(10);
        check(n_write, 2);
        aresetn <= 1'b0;
        cycles(4);
        aresetn <= 1'b1;
        cycles(2);
        rd_chk(flash_ctl_pkg::ctl_offset, 32'h0a, 32'h08);
        // config space selected: erase select must not erase a program row
        wr(flash_ctl_pkg::ctl_offset, 32'h40);
        unlock();
        wr(flash_ctl_pkg::ctl_offset, 32'h56);
        cycles(4);
        check(n_erase, 2);
        check(n_write, 3);
        report_and_stop();
    end
endmodule // flash_program_erase_control_bench
